/* guard_pkg.sv */
// package: command codes, field positions and timing of the sector guard
package guard_pkg;
	// clock and anti-guessing gap between password attempts
	localparam int CLK_MHZ        = 10;
	localparam int UNLOCK_GAP_US  = 100; // nominal, tolerance +/- 20 us
	localparam int UNLOCK_GAP_CYC = UNLOCK_GAP_US * CLK_MHZ;

	// command codes on the serial link
	localparam logic [7:0] OP_RD_STATUS = 8'h05;
	localparam logic [7:0] OP_CLR_STATUS = 8'h30;
	localparam logic [7:0] OP_SOFT_RESET = 8'hF0;
	localparam logic [7:0] OP_DYB_RD     = 8'hFA;
	localparam logic [7:0] OP_DYB_WR     = 8'hFB;
	localparam logic [7:0] OP_PPB_RD     = 8'hFC;
	localparam logic [7:0] OP_PPB_PROG   = 8'hFD;
	localparam logic [7:0] OP_PPB_ERASE  = 8'hE4;
	localparam logic [7:0] OP_LOCK_RD    = 8'hA7;
	localparam logic [7:0] OP_LOCK_CLR   = 8'hA6;
	localparam logic [7:0] OP_PASS_RD    = 8'hE7;
	localparam logic [7:0] OP_PASS_PROG  = 8'hE8;
	localparam logic [7:0] OP_UNLOCK     = 8'hE9;
	localparam logic [7:0] OP_ASP_RD     = 8'h2B;
	localparam logic [7:0] OP_ASP_PROG   = 8'h2F;

	// frame lengths in bytes, opcode included
	localparam logic [3:0] LEN_OP      = 4'h1;
	localparam logic [3:0] LEN_SEC     = 4'h2;
	localparam logic [3:0] LEN_SEC_VAL = 4'h3;
	localparam logic [3:0] LEN_PASS    = 4'h9;

	// status byte fields
	localparam int ST_WIP  = 0;
	localparam int ST_PERR = 6;

	// protection mode field, config bits 2:1
	localparam int         MODE_LSB      = 1;
	localparam logic [1:0] MODE_BLANK    = 2'h3;
	localparam logic [1:0] MODE_PERSIST  = 2'h2;
	localparam logic [1:0] MODE_PASSWORD = 2'h1;
	localparam logic [1:0] MODE_ILLEGAL  = 2'h0;

	localparam logic [63:0] PASS_BLANK = 64'hFFFF_FFFF_FFFF_FFFF;
	localparam logic [7:0]  BYTE_ZERO  = 8'h00;
endpackage

/* guard_link_if.sv */
// interface: four-wire serial link between host controller and device
`timescale 1ns/1ps
interface guard_link_if;
	logic sclk;
	logic cs_n;
	logic mosi;
	logic miso;

	modport host (output sclk, output cs_n, output mosi, input miso);
	modport device (input sclk, input cs_n, input mosi, output miso);
endinterface

/* serial_frame_port.sv */
// module: device-side serial shifter, bytes in on rise, bits out on fall
`timescale 1ns/1ps
module serial_frame_port
	import guard_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       sclk,
	input  wire logic       cs_n,
	input  wire logic       mosi,
	output logic            miso,
	input  wire logic       tx_load,
	input  wire logic [7:0] tx_byte,
	output logic            byte_stb,
	output logic [7:0]      rx_byte,
	output logic [3:0]      rx_idx,
	output logic            frame_end
);
	logic [2:0] sync1_ff;
	logic [2:0] sync2_ff;
	logic [1:0] prev_ff;
	logic [2:0] bit_ff;
	logic [7:0] sh_ff;
	logic [7:0] tx_ff;
	logic [3:0] cnt_ff;
	logic       rise;
	logic       fall;
	logic       sel;

	// ------------------------------------------------
	// pin synchronisers and edge detection
	// ------------------------------------------------
	always_ff @(posedge clk) begin
		sync1_ff <= {sclk, cs_n, mosi};
		sync2_ff <= sync1_ff;
		prev_ff  <= sync2_ff[2:1];
	end
	assign sel       = ~sync2_ff[1];
	assign rise      = sel & sync2_ff[2] & ~prev_ff[1];
	assign fall      = sel & ~sync2_ff[2] & prev_ff[1];
	assign frame_end = sync2_ff[1] & ~prev_ff[0];

	// ------------------------------------------------
	// receive shifter and byte counter
	// ------------------------------------------------
	always_ff @(posedge clk) begin
		byte_stb <= 1'b0;
		if (rst || !sel) begin
			bit_ff <= '0;
			cnt_ff <= '0;
		end else if (rise) begin
			sh_ff  <= {sh_ff[6:0], sync2_ff[0]};
			bit_ff <= bit_ff + 3'h1;
			if (bit_ff == 3'h7) begin
				byte_stb <= 1'b1;
				rx_byte  <= {sh_ff[6:0], sync2_ff[0]};
				rx_idx   <= cnt_ff;
				if (cnt_ff != 4'hF)
					cnt_ff <= cnt_ff + 4'h1; // saturate on long frames
			end
		end
	end

	// ------------------------------------------------
	// transmit shifter, msb first on each fall
	// ------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			tx_ff <= BYTE_ZERO;
			miso  <= 1'b0;
		end else if (tx_load) begin
			tx_ff <= tx_byte;
		end else if (fall) begin
			miso  <= tx_ff[7];
			tx_ff <= {tx_ff[6:0], 1'b0};
		end
	end
endmodule

/* sector_guard_device.sv */
// module: device end, per-sector guard bits, lock and password unlock
//
// How it works
// - volatile dynamic bit per sector, writable
// - protected when persistent or dynamic bit zero
// - lock bit gates every persistent bit change
// - dynamic bits writable whatever the lock
// - lock clear command forces lock to zero
// - persistent mode: reset sets lock
// - software reset leaves lock untouched
// - password mode: reset clears lock
// - unlock compares all 64 password bits
// - mismatch sets error, keeps busy, lock zero
// - unlock attempts spaced 100 us; host polls
// - match clears busy without delay
// - password program only clears bits
// - password blank all ones, own commands
// - password mode blocks password program, read
// - mode bits one-time, never erased
// - persistent bits survive resets
// - host clears lock after persistent setup
// - host follows manufacturing programming order
// - boot code sets freeze bit
// - locked persistent program, erase fail cleanly
// - program one sector, erase all together
// - final protection ORs block protection in
// - mode encoding 11, 10, 01; 00 fails
`timescale 1ns/1ps
module sector_guard_device
	import guard_pkg::*;
#(
	parameter int SECTORS = 256
) (
	input  wire logic               clk,
	input  wire logic               rst,
	guard_link_if.device            link,
	input  wire logic [SECTORS-1:0] bp_protect,
	output logic [SECTORS-1:0]      sector_protected,
	output logic                    guard_lock,
	output logic                    write_in_progress_flag,
	output logic                    prog_err,
	output logic [1:0]              guard_mode
);
	localparam int GAP_W = $clog2(UNLOCK_GAP_CYC + 1);
	localparam logic [GAP_W-1:0] GAP_LOAD = GAP_W'(UNLOCK_GAP_CYC);
	logic [SECTORS-1:0] dyb_ff;
	logic [SECTORS-1:0] ppb_ff  = '1;
	logic [63:0]        pass_ff = PASS_BLANK;
	logic [1:0]         mode_ff = MODE_BLANK;
	logic               lock_ff;
	logic               perr_ff;
	logic               wip_ff;
	logic [GAP_W-1:0]   gap_ff;
	logic [7:0]         op_ff;
	logic [63:0]        arg_ff;
	logic [3:0]         nbytes_ff;
	logic               tx_load_ff;
	logic [7:0]         tx_byte_ff;
	logic [7:0]         nxt_tx;
	logic               byte_stb;
	logic [7:0]         rx_byte;
	logic [3:0]         rx_idx;
	logic               frame_end;
	logic               exec;
	logic               pw_mode;
	logic               gap_idle;
	logic [7:0]         cur_op;
	logic [7:0]         wr_sec;
	logic [7:0]         pr_sec;
	logic [1:0]         new_mode;
	logic               try_unlock;
	logic               pass_ok;
	// expected frame length of each executing command, zero if none
	function automatic logic [3:0] cmd_len(input logic [7:0] op);
		case (op)
			OP_CLR_STATUS, OP_SOFT_RESET, OP_PPB_ERASE,
			OP_LOCK_CLR:  cmd_len = LEN_OP;
			OP_PPB_PROG, OP_ASP_PROG: cmd_len = LEN_SEC;
			OP_DYB_WR:    cmd_len = LEN_SEC_VAL;
			OP_PASS_PROG, OP_UNLOCK: cmd_len = LEN_PASS;
			default:      cmd_len = '0;
		endcase
	endfunction
	// sector number names a real sector
	function automatic logic in_range(input logic [7:0] s);
		in_range = 32'(s) < SECTORS;
	endfunction
	// ------------------------------------------------
	// link shifter
	// ------------------------------------------------
	serial_frame_port port_u (
		.clk(clk), .rst(rst), .sclk(link.sclk), .cs_n(link.cs_n),
		.mosi(link.mosi), .miso(link.miso), .tx_load(tx_load_ff),
		.tx_byte(tx_byte_ff), .byte_stb(byte_stb), .rx_byte(rx_byte),
		.rx_idx(rx_idx), .frame_end(frame_end));
	// ------------------------------------------------
	// frame capture and command decode
	// ------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst || frame_end) begin
			nbytes_ff <= '0;
		end else if (byte_stb) begin
			nbytes_ff <= rx_idx + 4'h1;
			if (rx_idx == '0)
				op_ff <= rx_byte;
			else
				arg_ff <= {arg_ff[55:0], rx_byte};
		end
	end
	// commands run at frame end; busy admits only status clear
	assign exec = frame_end && cmd_len(op_ff) != '0 &&
		nbytes_ff == cmd_len(op_ff) &&
		(!wip_ff || op_ff == OP_CLR_STATUS);
	assign pw_mode    = mode_ff == MODE_PASSWORD;
	assign gap_idle   = gap_ff == '0;
	assign wr_sec     = arg_ff[15:8];
	assign pr_sec     = arg_ff[7:0];
	assign new_mode   = arg_ff[MODE_LSB +: 2];
	assign try_unlock = exec && op_ff == OP_UNLOCK && pw_mode && gap_idle;
	assign pass_ok    = arg_ff == pass_ff;
	// ------------------------------------------------
	// read answers, loaded after each byte
	// ------------------------------------------------
	assign cur_op = (rx_idx == '0) ? rx_byte : op_ff;
	always_comb begin
		nxt_tx = BYTE_ZERO;
		case (cur_op)
			OP_RD_STATUS: begin
				nxt_tx[ST_WIP]  = wip_ff;
				nxt_tx[ST_PERR] = perr_ff;
			end
			OP_LOCK_RD: nxt_tx[0] = lock_ff;
			OP_DYB_RD: begin
				if (rx_idx != '0 && in_range(rx_byte))
					nxt_tx[0] = dyb_ff[rx_byte];
			end
			OP_PPB_RD: begin
				if (rx_idx != '0 && in_range(rx_byte))
					nxt_tx[0] = ppb_ff[rx_byte];
			end
			OP_PASS_RD: begin
				if (!pw_mode && rx_idx < 4'h8)
					nxt_tx = pass_ff[8*(7-rx_idx) +: 8];
			end
			OP_ASP_RD: begin
				nxt_tx = 8'hFF;
				nxt_tx[MODE_LSB +: 2] = mode_ff;
			end
			default: nxt_tx = BYTE_ZERO;
		endcase
	end
	always_ff @(posedge clk) begin
		tx_load_ff <= byte_stb;
		if (byte_stb)
			tx_byte_ff <= nxt_tx;
	end
	// ------------------------------------------------
	// non-volatile contents, blank at delivery
	// ------------------------------------------------
	// program one, erase all
	always_ff @(posedge clk) begin
		// lock gates, locked attempts no change
		if (exec && lock_ff) begin
			if (op_ff == OP_PPB_PROG && in_range(pr_sec))
				ppb_ff[pr_sec] <= 1'b0;
			else if (op_ff == OP_PPB_ERASE)
				ppb_ff <= '1;
		end
	end
	always_ff @(posedge clk) begin
		if (exec && op_ff == OP_PASS_PROG && !pw_mode)
			pass_ff <= pass_ff & arg_ff;
	end
	always_ff @(posedge clk) begin
		if (exec && op_ff == OP_ASP_PROG && mode_ff == MODE_BLANK &&
			new_mode != MODE_ILLEGAL)
			mode_ff <= new_mode;
	end
	// ------------------------------------------------
	// dynamic guard bits
	// ------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			dyb_ff <= '1;
		end else if (exec && op_ff == OP_SOFT_RESET) begin
			dyb_ff <= '1;
		end else if (exec && op_ff == OP_DYB_WR && in_range(wr_sec)) begin
			dyb_ff[wr_sec] <= arg_ff[0];
		end
	end
	// ------------------------------------------------
	// guard lock
	// ------------------------------------------------
	always_ff @(posedge clk) begin
		// persistent mode sets, password mode clears
		if (rst) begin
			lock_ff <= !pw_mode;
		end else if (exec && op_ff == OP_LOCK_CLR) begin
			lock_ff <= 1'b0;
		// outside reset, only a matching unlock sets it
		end else if (try_unlock && pass_ok) begin
			lock_ff <= 1'b1;
		end
		// soft reset has no branch here
	end
	// ------------------------------------------------
	// status flags and anti-guessing gap
	// ------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			gap_ff <= '0;
		end else if (try_unlock) begin
			gap_ff <= GAP_LOAD;
		end else if (!gap_idle) begin
			gap_ff <= gap_ff - GAP_W'(1);
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			wip_ff <= 1'b0;
		end else if (try_unlock && !pass_ok) begin
			wip_ff <= 1'b1;
		end else if (exec && op_ff == OP_CLR_STATUS && gap_idle) begin
			wip_ff <= 1'b0;
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			perr_ff <= 1'b0;
		end else if (exec) begin
			case (op_ff)
				OP_CLR_STATUS: if (gap_idle) perr_ff <= 1'b0;
				OP_SOFT_RESET: perr_ff <= 1'b0;
				OP_PPB_PROG, OP_PPB_ERASE:
					if (!lock_ff) perr_ff <= 1'b1;
				// second mode write or 00 fails
				OP_ASP_PROG:
					if (mode_ff != MODE_BLANK || new_mode == MODE_ILLEGAL)
						perr_ff <= 1'b1;
				OP_UNLOCK: if (try_unlock && !pass_ok) perr_ff <= 1'b1;
				default: perr_ff <= perr_ff;
			endcase
		end
	end
	// ------------------------------------------------
	// outputs
	// ------------------------------------------------
	always_ff @(posedge clk) begin
		// zero guard bit or block protect
		sector_protected <= ~ppb_ff | ~dyb_ff | bp_protect;
	end
	assign guard_lock = lock_ff;
	assign write_in_progress_flag        = wip_ff;
	assign prog_err   = perr_ff;
	assign guard_mode = mode_ff;
endmodule

/* sector_guard_host.sv */
// module: host end, sends one command frame and returns the read bytes
`timescale 1ns/1ps
module sector_guard_host
	import guard_pkg::*;
#(
	parameter int HALF_DIV = 4
) (
	input  wire logic        clk,
	input  wire logic        rst,
	guard_link_if.host       link,
	input  wire logic        cmd_valid,
	output logic             cmd_ready,
	input  wire logic [7:0]  cmd_op,
	input  wire logic [3:0]  cmd_wr_len,
	input  wire logic [63:0] cmd_wr_data,
	input  wire logic [3:0]  cmd_rd_len,
	output logic             resp_valid,
	output logic [63:0]      resp_data
);
	typedef enum logic [1:0] {
		S_IDLE = 2'b00,
		S_LOW  = 2'b01,
		S_HIGH = 2'b10,
		S_END  = 2'b11
	} state_e;

	localparam int DIV_W = $clog2(HALF_DIV + 1);
	localparam logic [DIV_W-1:0] DIV_TOP = DIV_W'(HALF_DIV - 1);

	state_e           state_ff;
	logic [DIV_W-1:0] div_ff;
	logic [71:0]      tx_ff;
	logic [7:0]       bits_ff;
	logic             miso1_ff;
	logic             miso2_ff;
	logic             tick;

	assign tick      = div_ff == DIV_TOP;
	assign cmd_ready = state_ff == S_IDLE;

	// ------------------------------------------------
	// miso synchroniser
	// ------------------------------------------------
	always_ff @(posedge clk) begin
		miso1_ff <= link.miso;
		miso2_ff <= miso1_ff;
	end

	// ------------------------------------------------
	// half-period divider for the link clock
	// ------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst || state_ff == S_IDLE || tick)
			div_ff <= '0;
		else
			div_ff <= div_ff + DIV_W'(1);
	end

	// ------------------------------------------------
	// frame sequencer
	// ------------------------------------------------
	// caller polls busy before the next unlock
	always_ff @(posedge clk) begin
		resp_valid <= 1'b0;
		if (rst) begin
			state_ff  <= S_IDLE;
			link.sclk <= 1'b0;
			link.cs_n <= 1'b1;
			link.mosi <= 1'b0;
			bits_ff   <= '0;
			resp_data <= '0;
		end else begin
			case (state_ff)
				S_IDLE: begin
					if (cmd_valid) begin
						tx_ff <= {cmd_op, cmd_wr_data <<
							(8 * (8 - 32'(cmd_wr_len)))};
						bits_ff <= 8'(8 * (1 + 32'(cmd_wr_len) +
							32'(cmd_rd_len)));
						link.cs_n <= 1'b0;
						link.mosi <= cmd_op[7];
						state_ff  <= S_LOW;
					end
				end
				S_LOW: begin
					if (tick) begin
						link.sclk <= 1'b1;
						state_ff  <= S_HIGH;
					end
				end
				S_HIGH: begin
					if (tick) begin
						link.sclk <= 1'b0;
						resp_data <= {resp_data[62:0], miso2_ff};
						bits_ff   <= bits_ff - 8'h01;
						tx_ff     <= {tx_ff[70:0], 1'b0};
						link.mosi <= tx_ff[70];
						if (bits_ff == 8'h01) begin
							link.cs_n <= 1'b1;
							state_ff  <= S_END;
						end else begin
							state_ff <= S_LOW;
						end
					end
				end
				S_END: begin
					if (tick) begin
						resp_valid <= 1'b1;
						state_ff   <= S_IDLE;
					end
				end
				default: state_ff <= S_IDLE;
			endcase
		end
	end
endmodule

/* sector_guard_checker.sv */
// checker: lock, busy and protection assertions for the sector guard
`timescale 1ns/1ps
module sector_guard_checker
	import guard_pkg::*;
#(
	parameter int SECTORS = 256
) (
	input wire logic               clk,
	input wire logic               rst,
	input wire logic               sclk,
	input wire logic               cs_n,
	input wire logic               mosi,
	input wire logic               miso,
	input wire logic [SECTORS-1:0] bp_protect,
	input wire logic [SECTORS-1:0] sector_protected,
	input wire logic               guard_lock,
	input wire logic               write_in_progress_flag,
	input wire logic               prog_err,
	input wire logic [1:0]         guard_mode
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	logic [10:0] busy_cnt_ff;

	// cycles the busy flag has been high
	always_ff @(posedge clk) begin
		if (rst || !write_in_progress_flag) begin
			busy_cnt_ff <= 11'h000;
		end else if (busy_cnt_ff != 11'h7FF) begin
			busy_cnt_ff <= busy_cnt_ff + 11'h001;
		end
	end

	property p_bp_or;
		!$past(rst) && !$past(rst, 2) |->
			($past(bp_protect) & $past(bp_protect, 2) & ~sector_protected) == '0;
	endproperty
	a_bp_or: assert property (p_bp_or) else $error("block protect lost");

	property p_rst_persist;
		$fell(rst) && guard_mode != MODE_PASSWORD |-> guard_lock;
	endproperty
	a_rst_persist: assert property (p_rst_persist) else $error("lock clear");

	property p_rst_pass;
		$fell(rst) && guard_mode == MODE_PASSWORD |-> !guard_lock;
	endproperty
	a_rst_pass: assert property (p_rst_pass) else $error("lock set");

	property p_lock_rise;
		$rose(guard_lock) |-> guard_mode == MODE_PASSWORD && !write_in_progress_flag;
	endproperty
	a_lock_rise: assert property (p_lock_rise) else $error("lock rose");

	property p_busy_err;
		$rose(write_in_progress_flag) |-> prog_err && !guard_lock;
	endproperty
	a_busy_err: assert property (p_busy_err) else $error("bad mismatch");

	property p_busy_hold;
		$rose(write_in_progress_flag) |=> write_in_progress_flag [*8];
	endproperty
	a_busy_hold: assert property (p_busy_hold) else $error("busy dropped");

	property p_busy_gap;
		$fell(write_in_progress_flag) |-> busy_cnt_ff >= 11'h320;
	endproperty
	a_busy_gap: assert property (p_busy_gap) else $error("gap too short");

	property p_mode_once;
		$changed(guard_mode) |->
			$past(guard_mode) == MODE_BLANK && guard_mode != MODE_ILLEGAL;
	endproperty
	a_mode_once: assert property (p_mode_once) else $error("mode change");

	// link clock parked and lines quiet between frames
	property p_link_idle;
		cs_n && $past(cs_n) |-> !sclk && $stable(mosi) && $stable(miso);
	endproperty
	a_link_idle: assert property (p_link_idle) else $error("link moved idle");
endmodule

/* tb_top.sv */
// testbench: host and device ends joined over the serial link
`timescale 1ns/1ps
module tb_top
	import guard_pkg::*;
;
	localparam logic [63:0] PW_A = 64'h0123_4567_89AB_CDEF;
	localparam logic [63:0] PW_B = 64'hF0F0_F0F0_FFFF_FFFF;
	localparam logic [63:0] PW   = PW_A & PW_B;

	logic         clk;
	logic         rst;
	logic         cmd_valid;
	logic         cmd_ready;
	logic [7:0]   cmd_op;
	logic [3:0]   cmd_wr_len;
	logic [63:0]  cmd_wr_data;
	logic [3:0]   cmd_rd_len;
	logic         resp_valid;
	logic [63:0]  resp_data;
	logic [255:0] bp_protect;
	logic [255:0] sector_protected;
	logic         guard_lock;
	logic         write_in_progress_flag;
	logic         prog_err;
	logic [1:0]   guard_mode;
	int           error_cnt;
	int           checks;
	int           n;

	guard_link_if link ();

	sector_guard_host sector_guard_host_i (
		.clk(clk), .rst(rst), .link(link), .cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_wr_len(cmd_wr_len),
		.cmd_wr_data(cmd_wr_data), .cmd_rd_len(cmd_rd_len),
		.resp_valid(resp_valid), .resp_data(resp_data));

	sector_guard_device sector_guard_device_i (
		.clk(clk), .rst(rst), .link(link), .bp_protect(bp_protect),
		.sector_protected(sector_protected), .guard_lock(guard_lock),
		.write_in_progress_flag(write_in_progress_flag), .prog_err(prog_err), .guard_mode(guard_mode));

	sector_guard_checker #(.SECTORS(256)) sector_guard_checker_i (
		.clk(clk), .rst(rst), .sclk(link.sclk), .cs_n(link.cs_n),
		.mosi(link.mosi), .miso(link.miso), .bp_protect(bp_protect),
		.sector_protected(sector_protected), .guard_lock(guard_lock),
		.write_in_progress_flag(write_in_progress_flag), .prog_err(prog_err), .guard_mode(guard_mode));

	// clock source
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// ------------------------------
	// tasks
	// ------------------------------
	task automatic conclude();
		$display("checks %0d errors %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic tick(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask

	task automatic hw_reset();
		rst = 1'b1;
		tick(4);
		rst = 1'b0;
		tick(2);
	endtask

	// one whole frame, held until taken, then settle
	task automatic xfer(input logic [7:0] op, input logic [3:0] wl,
		input logic [63:0] wd, input logic [3:0] rl);
		int k;
		cmd_op = op;
		cmd_wr_len = wl;
		cmd_wr_data = wd;
		cmd_rd_len = rl;
		cmd_valid = 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (cmd_ready !== 1'b1 && k < 9);
		if (cmd_ready !== 1'b1) begin
			error_cnt++;
			conclude();
		end
		#1;
		cmd_valid = 1'b0;
		k = 0;
		while (resp_valid !== 1'b1) begin
			@(posedge clk);
			k++;
			if (k > 3000) begin
				error_cnt++;
				conclude();
			end
		end
		tick(6);
	endtask

	task automatic op1(input logic [7:0] op);
		xfer(op, 4'h0, 64'h0, 4'h0);
	endtask

	task automatic rd(input logic [7:0] op, input logic [3:0] wl,
		input logic [63:0] wd, input logic [3:0] rl, input logic [63:0] exp);
		logic [63:0] mask;
		xfer(op, wl, wd, rl);
		mask = (rl == 4'h8) ? PASS_BLANK : ((64'h1 << (8 * rl)) - 64'h1);
		check(resp_data & mask, exp);
	endtask

	task automatic stat(input logic [63:0] exp);
		rd(OP_RD_STATUS, 4'h0, 64'h0, 4'h1, exp);
	endtask

	// ------------------------------
	// main sequence
	// ------------------------------
	initial begin
		rst = 1'b1;
		cmd_valid = 1'b0;
		cmd_op = 8'h00;
		cmd_wr_len = 4'h0;
		cmd_wr_data = 64'h0;
		cmd_rd_len = 4'h0;
		bp_protect = '0;
		error_cnt = 0;
		checks = 0;
		hw_reset();
		check(guard_lock, 1'b1);
		rd(OP_LOCK_RD, 4'h0, 64'h0, 4'h1, 64'h1);
		xfer(OP_DYB_WR, 4'h2, 64'h0500, 4'h0);
		check(sector_protected[5], 1'b1);
		rd(OP_DYB_RD, 4'h1, 64'h05, 4'h1, 64'h0);
		xfer(OP_DYB_WR, 4'h2, 64'h0501, 4'h0);
		check(sector_protected[5], 1'b0);
		xfer(OP_PPB_PROG, 4'h1, 64'h07, 4'h0);
		rd(OP_PPB_RD, 4'h1, 64'h07, 4'h1, 64'h0);
		rd(OP_PPB_RD, 4'h1, 64'h08, 4'h1, 64'h1);
		check(sector_protected[8:7], 2'b01);
		bp_protect[9] = 1'b1;
		tick(3);
		check(sector_protected[9], 1'b1);
		bp_protect[9] = 1'b0;
		// lock cleared once persistent bits set
		op1(OP_LOCK_CLR);
		check(guard_lock, 1'b0);
		xfer(OP_PPB_PROG, 4'h1, 64'h03, 4'h0);
		op1(OP_PPB_ERASE);
		rd(OP_PPB_RD, 4'h1, 64'h03, 4'h1, 64'h1);
		rd(OP_PPB_RD, 4'h1, 64'h07, 4'h1, 64'h0);
		stat(64'h40);
		op1(OP_CLR_STATUS);
		xfer(OP_DYB_WR, 4'h2, 64'h0300, 4'h0);
		check(sector_protected[3], 1'b1);
		xfer(OP_UNLOCK, 4'h8, PASS_BLANK, 4'h0);
		op1(OP_SOFT_RESET);
		check(guard_lock, 1'b0);
		check(sector_protected[3], 1'b0);
		hw_reset();
		check(guard_lock, 1'b1);
		rd(OP_PPB_RD, 4'h1, 64'h07, 4'h1, 64'h0);
		op1(OP_PPB_ERASE);
		rd(OP_PPB_RD, 4'h1, 64'h07, 4'h1, 64'h1);
		rd(OP_PASS_RD, 4'h0, 64'h0, 4'h8, PASS_BLANK);
		xfer(OP_PASS_PROG, 4'h8, PW_A, 4'h0);
		xfer(OP_PASS_PROG, 4'h8, PW_B, 4'h0);
		rd(OP_PASS_RD, 4'h0, 64'h0, 4'h8, PW);
		stat(64'h00);
		xfer(OP_ASP_PROG, 4'h1, 64'hF9, 4'h0);
		check(guard_mode, MODE_BLANK);
		stat(64'h40);
		op1(OP_CLR_STATUS);
		xfer(OP_ASP_PROG, 4'h1, 64'hFB, 4'h0);
		rd(OP_ASP_RD, 4'h0, 64'h0, 4'h1, 64'hFB);
		xfer(OP_ASP_PROG, 4'h1, 64'hFD, 4'h0);
		check(guard_mode, MODE_PASSWORD);
		op1(OP_CLR_STATUS);
		rd(OP_PASS_RD, 4'h0, 64'h0, 4'h8, 64'h0);
		// ignored program, later unlock still matches
		xfer(OP_PASS_PROG, 4'h8, 64'h0, 4'h0);
		hw_reset();
		check(guard_lock, 1'b0);
		xfer(OP_UNLOCK, 4'h8, PW ^ 64'h8000_0000_0000_0000, 4'h0);
		op1(OP_CLR_STATUS);
		stat(64'h41);
		check({prog_err, write_in_progress_flag}, 2'b11);
		xfer(OP_UNLOCK, 4'h8, PW, 4'h0);
		check(guard_lock, 1'b0);
		n = 0;
		do begin
			op1(OP_CLR_STATUS);
			xfer(OP_RD_STATUS, 4'h0, 64'h0, 4'h1);
			n++;
		end while (resp_data[0] !== 1'b0 && n < 20);
		check(resp_data[7:0], 8'h00);
		xfer(OP_UNLOCK, 4'h8, PW, 4'h0);
		check({write_in_progress_flag, guard_lock}, 2'b01);
		xfer(OP_PPB_PROG, 4'h1, 64'h0B, 4'h0);
		check(sector_protected[11], 1'b1);
		op1(OP_LOCK_CLR);
		check(guard_lock, 1'b0);
		conclude();
	end
endmodule
